/* rtl/ptc_pkg.sv */
// Package for the periodic timer compare and PWM block
package ptc_pkg;
  // ----------------------------------------
  // Register offsets (byte wide registers)
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL_ZERO = 4'h0;
  localparam logic [3:0] ADDR_CTRL_ONE = 4'h1;
  localparam logic [3:0] ADDR_COUNT_LOW = 4'h2;
  localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
  localparam logic [3:0] ADDR_CMPA_LOW = 4'h4;
  localparam logic [3:0] ADDR_CMPA_HIGH = 4'h5;
  localparam logic [3:0] ADDR_CMPP_LOW = 4'h6;
  localparam logic [3:0] ADDR_CMPP_HIGH = 4'h7;
  localparam logic [3:0] ADDR_FLAGS = 4'h8;
  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int CTRL0_ON_BIT = 3;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [9:0] COUNT_ZERO = 10'h000;
  localparam logic [9:0] COUNT_MAX = 10'h3ff;
  localparam logic [9:0] COUNT_ONE = 10'h001;
  localparam logic [5:0] HIGH_PAD = 6'h00;
  localparam logic [2:0] CTRL0_PAD = 3'h0;
  localparam logic [1:0] FLAG_PAD_ZERO = 2'h0;
  localparam logic [5:0] FLAG_PAD = 6'h00;

  typedef enum logic [1:0]
  {
    MODE_COMPARE = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TIMER = 2'b11
  } ptc_mode_t;

  typedef enum logic [1:0]
  {
    FUNC_00 = 2'b00,
    FUNC_01 = 2'b01,
    FUNC_10 = 2'b10,
    FUNC_11 = 2'b11
  } ptc_func_t;

  // Control register one layout, bit 7 down to bit 0
  typedef struct packed
  {
    ptc_mode_t mode;
    ptc_func_t func;
    logic init_level;
    logic invert;
    logic capture_src;
    logic clear_src;
  } ptc_ctrl_t;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ptc_bus_t;
endpackage

/* rtl/ptc_timer.sv */
// Periodic timer with compare match, timer/counter and PWM modes
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module ptc_timer
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire ptc_pkg::ptc_bus_t bus,
  output logic [7:0] rdata,
  output logic timer_out,
  output logic timer_out_en,
  output logic compare_a_match_flag,
  output logic compare_p_match_flag
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic counter_on_reg;
  logic counter_on_d_reg;
  ptc_pkg::ptc_ctrl_t ctrl_reg;
  logic [9:0] count_reg;
  logic [9:0] count_next;
  logic [9:0] cmpa_reg;
  logic [9:0] cmpp_reg;
  logic flag_a_reg;
  logic flag_p_reg;
  logic pin_reg;
  logic pin_en_reg;
  logic [7:0] rdata_reg;
  logic on_rise;
  logic match_a;
  logic match_p;
  logic overflow;
  logic set_a;
  logic set_p;
  logic clear_cnt;
  logic is_pwm;
  logic is_cmp;
  logic pwm_active;
  logic pwm_level;
  logic wr_flags;
  logic period_end;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Compare values written per byte
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      counter_on_reg <= 1'b0;
      ctrl_reg <= '0;
      cmpa_reg <= ptc_pkg::COUNT_ZERO;
      cmpp_reg <= ptc_pkg::COUNT_ZERO;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        ptc_pkg::ADDR_CTRL_ZERO: counter_on_reg <= bus.wdata[ptc_pkg::CTRL0_ON_BIT];
        ptc_pkg::ADDR_CTRL_ONE: ctrl_reg <= ptc_pkg::ptc_ctrl_t'(bus.wdata);
        ptc_pkg::ADDR_CMPA_LOW: cmpa_reg[7:0] <= bus.wdata;
        ptc_pkg::ADDR_CMPA_HIGH: cmpa_reg[9:8] <= bus.wdata[1:0];
        ptc_pkg::ADDR_CMPP_LOW: cmpp_reg[7:0] <= bus.wdata;
        ptc_pkg::ADDR_CMPP_HIGH: cmpp_reg[9:8] <= bus.wdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      counter_on_d_reg <= 1'b0;
    else
      counter_on_d_reg <= counter_on_reg;
  end

  assign on_rise = counter_on_reg & ~counter_on_d_reg;
  assign is_pwm = (ctrl_reg.mode == ptc_pkg::MODE_PWM);
  assign is_cmp = (ctrl_reg.mode == ptc_pkg::MODE_COMPARE);
  // Zero A unmatched
  // Zero compare A never matches, so an A clear source runs to overflow
  assign match_a = counter_on_d_reg & (cmpa_reg != ptc_pkg::COUNT_ZERO)
    & (count_reg == cmpa_reg);
  assign match_p = counter_on_d_reg & (cmpp_reg != ptc_pkg::COUNT_ZERO)
    & (count_reg == cmpp_reg);
  assign overflow = counter_on_d_reg & (count_reg == ptc_pkg::COUNT_MAX);
  // Zero compare P puts the period end at 3FF, which is the overflow
  assign period_end = counter_on_d_reg
    & (count_reg == cmpp_reg - ptc_pkg::COUNT_ONE);

  // ----------------------------------------
  // Counter clear and flags
  // ----------------------------------------
  always_comb
  begin
    set_a = match_a;
    set_p = match_p;
    clear_cnt = overflow;
    if (is_pwm)
    begin
      // P match sets period, clear-source ignored
      // Period equals compare P, zero wraps at 1024
      clear_cnt = period_end;
      set_p = period_end & (cmpp_reg != ptc_pkg::COUNT_ZERO);
    end
    else if (ctrl_reg.clear_src)
    begin
      // A match clears, no P flag
      set_p = 1'b0;
      clear_cnt = match_a | overflow;
    end
    else
    begin
      clear_cnt = match_p | overflow;
    end
  end

  always_comb
  begin
    count_next = count_reg;
    if (on_rise)
      count_next = ptc_pkg::COUNT_ZERO;
    else if (counter_on_d_reg)
      count_next = clear_cnt ? ptc_pkg::COUNT_ZERO : count_reg + ptc_pkg::COUNT_ONE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      count_reg <= ptc_pkg::COUNT_ZERO;
    else
      count_reg <= count_next;
  end

  assign wr_flags = bus.wr & (bus.addr == ptc_pkg::ADDR_FLAGS);

  // Sticky flags, set wins over write-one-to-clear
  // Flags keep running whatever the function
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end
    else
    begin
      if (set_a)
        flag_a_reg <= 1'b1;
      else if (wr_flags & bus.wdata[ptc_pkg::FLAG_A_BIT])
        flag_a_reg <= 1'b0;
      if (set_p)
        flag_p_reg <= 1'b1;
      else if (wr_flags & bus.wdata[ptc_pkg::FLAG_P_BIT])
        flag_p_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // Output pin
  // ----------------------------------------
  // Active from clear until compare A
  // Duty at or past period stays active
  assign pwm_active = (count_reg < cmpa_reg)
    | ((cmpp_reg != ptc_pkg::COUNT_ZERO) & (cmpa_reg >= cmpp_reg));

  always_comb
  begin
    case (ctrl_reg.func)
      ptc_pkg::FUNC_00: pwm_level = ~ctrl_reg.init_level;
      ptc_pkg::FUNC_01: pwm_level = ctrl_reg.init_level;
      ptc_pkg::FUNC_10: pwm_level = pwm_active ? ctrl_reg.init_level : ~ctrl_reg.init_level;
      // Holding must undo the invert, else the pin toggles every clock
      default: pwm_level = pin_reg ^ ctrl_reg.invert;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_reg <= 1'b0;
      pin_en_reg <= 1'b0;
    end
    else
    begin
      // Timer mode leaves the pin free
      pin_en_reg <= is_cmp | is_pwm;
      if (is_pwm)
        pin_reg <= pwm_level ^ ctrl_reg.invert;
      else if (on_rise)
        pin_reg <= ctrl_reg.init_level ^ ctrl_reg.invert;
      else if (is_cmp & set_a)
      begin
        // P match has no branch here
        case (ctrl_reg.func)
          ptc_pkg::FUNC_01: pin_reg <= ctrl_reg.invert;
          ptc_pkg::FUNC_10: pin_reg <= ~ctrl_reg.invert;
          ptc_pkg::FUNC_11: pin_reg <= ~pin_reg;
          default: pin_reg <= pin_reg;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rdata_reg <= ptc_pkg::BYTE_ZERO;
    else if (bus.rd)
    begin
      case (bus.addr)
        ptc_pkg::ADDR_CTRL_ZERO: rdata_reg <= {ptc_pkg::FLAG_PAD[3:0], counter_on_reg,
          ptc_pkg::CTRL0_PAD};
        ptc_pkg::ADDR_CTRL_ONE: rdata_reg <= ctrl_reg;
        ptc_pkg::ADDR_COUNT_LOW: rdata_reg <= count_reg[7:0];
        ptc_pkg::ADDR_COUNT_HIGH: rdata_reg <= {ptc_pkg::HIGH_PAD, count_reg[9:8]};
        ptc_pkg::ADDR_CMPA_LOW: rdata_reg <= cmpa_reg[7:0];
        ptc_pkg::ADDR_CMPA_HIGH: rdata_reg <= {ptc_pkg::HIGH_PAD, cmpa_reg[9:8]};
        ptc_pkg::ADDR_CMPP_LOW: rdata_reg <= cmpp_reg[7:0];
        ptc_pkg::ADDR_CMPP_HIGH: rdata_reg <= {ptc_pkg::HIGH_PAD, cmpp_reg[9:8]};
        ptc_pkg::ADDR_FLAGS: rdata_reg <= {ptc_pkg::FLAG_PAD, flag_p_reg, flag_a_reg};
        default: rdata_reg <= ptc_pkg::BYTE_ZERO;
      endcase
    end
    else
      rdata_reg <= ptc_pkg::BYTE_ZERO;
  end

  assign rdata = rdata_reg;
  assign timer_out = pin_reg;
  assign timer_out_en = pin_en_reg;
  assign compare_a_match_flag = flag_a_reg;
  assign compare_p_match_flag = flag_p_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_on_rise;
    counter_on_reg && !counter_on_d_reg;
  endsequence

  chk_count_restart: assert property (s_on_rise |=> count_reg == ptc_pkg::COUNT_ZERO)
    else $error("counter not zeroed on enable");
  chk_count_hold: assert property (!counter_on_reg && !counter_on_d_reg |=> $stable(count_reg))
    else $error("counter moved while off");
  chk_no_p_flag: assert property (
    !is_pwm && ctrl_reg.clear_src && !flag_p_reg && !wr_flags |=> !flag_p_reg)
    else $error("P flag raised with A clear source");
  chk_flag_sticky: assert property (flag_a_reg && !wr_flags |=> flag_a_reg)
    else $error("A flag dropped without clear");
  chk_flag_set: assert property (match_a |=> flag_a_reg)
    else $error("A match did not raise flag");
  chk_zero_a_flag: assert property (
    cmpa_reg == ptc_pkg::COUNT_ZERO && !flag_a_reg && !bus.wr |=> !flag_a_reg)
    else $error("A flag with zero compare A");
  chk_p_clear: assert property (
    !is_pwm && !ctrl_reg.clear_src && match_p && !on_rise |=> count_reg == ptc_pkg::COUNT_ZERO)
    else $error("P match did not clear counter");
  chk_timer_pin: assert property (
    ctrl_reg.mode == ptc_pkg::MODE_TIMER && !bus.wr |=> !timer_out_en)
    else $error("pin driven in timer mode");
  chk_init_level: assert property (
    s_on_rise ##0 is_cmp ##0 !bus.wr |=> pin_reg == (ctrl_reg.init_level ^ ctrl_reg.invert))
    else $error("pin not at initial level");
  chk_pwm_force: assert property (
    is_pwm && ctrl_reg.func == ptc_pkg::FUNC_01 && !bus.wr
    |=> pin_reg == (ctrl_reg.init_level ^ ctrl_reg.invert))
    else $error("forced active level wrong");

  // ----------------------------------------
  // Checks on clearing, pin and read-back
  // ----------------------------------------
  // Bus writes are left out where a new setting may legally move the pin
  sequence s_pwm_wrap;
    is_pwm && counter_on_d_reg && (cmpp_reg != ptc_pkg::COUNT_ZERO)
      && (count_reg == cmpp_reg - ptc_pkg::COUNT_ONE);
  endsequence

  sequence s_cmp_quiet;
    is_cmp && !set_a && !on_rise;
  endsequence

  sequence s_pwm_steady;
    is_pwm && !bus.wr;
  endsequence

  // PWM clears one short of compare P, so that end stands for the P match
  chk_pwm_p_flag: assert property (s_pwm_wrap
    |=> count_reg == ptc_pkg::COUNT_ZERO && flag_p_reg)
    else $error("PWM period end missed P flag");
  chk_a_clear: assert property (
    !is_pwm && ctrl_reg.clear_src && match_a |=> count_reg == ptc_pkg::COUNT_ZERO)
    else $error("A match did not clear counter");
  chk_overflow_wrap: assert property (
    counter_on_d_reg && count_reg == ptc_pkg::COUNT_MAX |=> count_reg == ptc_pkg::COUNT_ZERO)
    else $error("counter did not wrap after 3FF");
  chk_count_step: assert property (
    counter_on_d_reg && !clear_cnt |=> count_reg == $past(count_reg) + ptc_pkg::COUNT_ONE)
    else $error("counter did not advance by one");

  // Comparator P has no path to the pin in compare mode
  chk_cmp_pin_quiet: assert property (s_cmp_quiet |=> $stable(pin_reg))
    else $error("pin moved without an A match");
  chk_pin_enable: assert property (is_cmp |=> timer_out_en)
    else $error("pin not driven in compare mode");
  // A match in the same cycle wins, so only a quiet cycle must clear
  chk_a_flag_clear: assert property (
    wr_flags && bus.wdata[ptc_pkg::FLAG_A_BIT] && !set_a |=> !flag_a_reg)
    else $error("A flag not cleared by write");
  chk_p_flag_clear: assert property (
    wr_flags && bus.wdata[ptc_pkg::FLAG_P_BIT] && !set_p |=> !flag_p_reg)
    else $error("P flag not cleared by write");

  chk_pwm_inactive: assert property (
    s_pwm_steady ##0 (ctrl_reg.func == ptc_pkg::FUNC_00)
    |=> pin_reg == (~ctrl_reg.init_level ^ ctrl_reg.invert))
    else $error("forced inactive level wrong");
  // Zero compare P is a 1024 period, which no duty value can reach
  chk_pwm_full: assert property (
    s_pwm_steady ##0 (ctrl_reg.func == ptc_pkg::FUNC_10
    && cmpp_reg != ptc_pkg::COUNT_ZERO && cmpa_reg >= cmpp_reg)
    |=> pin_reg == (ctrl_reg.init_level ^ ctrl_reg.invert))
    else $error("full duty not held active");
  chk_pwm_hold: assert property (
    s_pwm_steady ##0 (ctrl_reg.func == ptc_pkg::FUNC_11) |=> $stable(pin_reg))
    else $error("pin moved with hold function");
  // Unused upper bits must read zero whatever the counter holds
  chk_count_high_read: assert property (
    bus.rd && bus.addr == ptc_pkg::ADDR_COUNT_HIGH |=> rdata_reg[7:2] == ptc_pkg::HIGH_PAD)
    else $error("counter high upper bits not zero");
endmodule

/* bench/ptc_timer_tb.sv */
// Self-checking testbench for the periodic timer block
`timescale 1ns/1ps
module ptc_timer_tb;
  logic clk_sys;
  logic rst;
  ptc_pkg::ptc_bus_t bus;
  logic [7:0] rdata;
  logic timer_out;
  logic timer_out_en;
  logic flag_a;
  logic flag_p;
  int errors;
  int n_checks;
  int cyc;
  logic [7:0] d;
  logic [7:0] d2;
  int h;

  ptc_timer dut_u
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .timer_out(timer_out),
    .timer_out_en(timer_out_en),
    .compare_a_match_flag(flag_a),
    .compare_p_match_flag(flag_p)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Run is about 3000 cycles; the ceiling leaves wide margin
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe edge
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  // Flags are cleared while stopped, since a match beats a clear
  task setup(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
    wr(ptc_pkg::ADDR_CTRL_ZERO, 8'h00);
    wr(ptc_pkg::ADDR_FLAGS, 8'h03);
    wr(ptc_pkg::ADDR_CMPA_LOW, a[7:0]);
    wr(ptc_pkg::ADDR_CMPA_HIGH, {6'h00, a[9:8]});
    wr(ptc_pkg::ADDR_CMPP_LOW, p[7:0]);
    wr(ptc_pkg::ADDR_CMPP_HIGH, {6'h00, p[9:8]});
    wr(ptc_pkg::ADDR_CTRL_ONE, c1);
    wr(ptc_pkg::ADDR_CTRL_ZERO, 8'h08);
  endtask

  task wait_flag(input bit sel);
    int k;
    k = 0;
    while (((sel ? flag_p : flag_a) !== 1'b1) && k < 2000)
    begin
      @(negedge clk_sys);
      k++;
    end
  endtask

  task hi_count(input int n);
    h = 0;
    repeat (n)
    begin
      @(negedge clk_sys);
      if (timer_out === 1'b1)
        h++;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    rd(ptc_pkg::ADDR_COUNT_HIGH, d); chk("count_high reset", d, 16'h00);
    for (int i = 4; i < 8; i++)
    begin
      rd(i[3:0], d); chk("compare reset", d, 16'h00);
    end
    wr(ptc_pkg::ADDR_CMPA_HIGH, 8'hff);
    rd(ptc_pkg::ADDR_CMPA_HIGH, d); chk("cmpa high", d, 16'h03);
    wr(ptc_pkg::ADDR_CMPA_LOW, 8'ha5);
    rd(ptc_pkg::ADDR_CMPA_LOW, d); chk("cmpa low", d, 16'ha5);
    wr(ptc_pkg::ADDR_CMPP_HIGH, 8'hff);
    rd(ptc_pkg::ADDR_CMPP_HIGH, d); chk("cmpp high", d, 16'h03);
    wr(ptc_pkg::ADDR_COUNT_HIGH, 8'hff);
    rd(ptc_pkg::ADDR_COUNT_HIGH, d); chk("count_high ro", d, 16'h00);
    rd(4'hf, d); chk("unmapped", d, 16'h00);
    $display("test regs done");
  endtask

  task t_compare;
    logic [3:0] init_t;
    logic [3:0] exp_t;
    init_t = 4'b0011;
    exp_t = 4'b1101;
    for (int f = 0; f < 4; f++)
    begin
      setup({2'b00, f[1:0], init_t[f], 3'b000}, 10'd20, 10'd40);
      repeat (2) @(negedge clk_sys);
      chk("pin init", timer_out, init_t[f]);
      chk("pin enable", timer_out_en, 1'b1);
      wait_flag(1'b0);
      repeat (2) @(negedge clk_sys);
      chk("pin on a", timer_out, exp_t[f]);
      wait_flag(1'b1);
      chk("flag p", flag_p, 1'b1);
      chk("pin on p", timer_out, exp_t[f]);
      rd(ptc_pkg::ADDR_COUNT_LOW, d); chk("clear on p", d < 8'd40, 1'b1);
    end
    $display("test compare done");
  endtask

  task t_clear_a;
    setup(8'h01, 10'd10, 10'd4);
    repeat (60) @(negedge clk_sys);
    chk("flag a", flag_a, 1'b1);
    chk("no flag p", flag_p, 1'b0);
    rd(ptc_pkg::ADDR_COUNT_LOW, d); chk("clear on a", d <= 8'd10, 1'b1);
    wr(ptc_pkg::ADDR_CTRL_ZERO, 8'h00);
    chk("flag sticky", flag_a, 1'b1);
    rd(ptc_pkg::ADDR_COUNT_LOW, d);
    repeat (5) @(negedge clk_sys);
    rd(ptc_pkg::ADDR_COUNT_LOW, d2); chk("count held", d2, d);
    wr(ptc_pkg::ADDR_FLAGS, 8'h03);
    @(negedge clk_sys);
    chk("flag cleared", flag_a, 1'b0);
    setup(8'hc0, 10'd5, 10'd9);
    repeat (40) @(negedge clk_sys);
    chk("timer no pin", timer_out_en, 1'b0);
    chk("timer flags", {flag_a, flag_p}, 2'b11);
    setup(8'h00, 10'd0, 10'd0);
    repeat (1100) @(negedge clk_sys);
    chk("a zero no flag", flag_a, 1'b0);
    $display("test clear and timer done");
  endtask

  task t_pwm;
    logic [7:0] c1_t [7];
    logic [9:0] a_t [7];
    int hi_t [7];
    c1_t = '{8'ha8, 8'ha9, 8'ha0, 8'hac, 8'ha8, 8'h88, 8'h98};
    a_t = '{10'd3, 10'd3, 10'd3, 10'd3, 10'd8, 10'd3, 10'd3};
    hi_t = '{6, 6, 10, 10, 16, 0, 16};
    for (int i = 0; i < 7; i++)
    begin
      setup(c1_t[i], a_t[i], 10'd8);
      repeat (12) @(negedge clk_sys);
      hi_count(16);
      // One 16-cycle window spans two whole periods of 8
      chk("pwm high count", h[15:0], hi_t[i][15:0]);
      chk("pwm flag p", flag_p, 1'b1);
      if (a_t[i] < 10'd8)
      begin
        chk("pwm flag a", flag_a, 1'b1);
      end
    end
    $display("test pwm done");
  endtask

  task t_more;
    logic p0;
    setup(8'h0c, 10'd20, 10'd40);
    repeat (2) @(negedge clk_sys);
    chk("pin init inverted", timer_out, 1'b0);
    setup(8'h40, 10'd5, 10'd9);
    repeat (2) @(negedge clk_sys);
    chk("capture no pin", timer_out_en, 1'b0);
    setup(8'ha8, 10'd256, 10'd0);
    repeat (4) @(negedge clk_sys);
    hi_count(1024);
    chk("pwm long period", h[15:0], 16'd256);
    // Hold with invert set catches a pin that flips every clock
    setup(8'hb4, 10'd3, 10'd8);
    @(negedge clk_sys);
    p0 = timer_out;
    repeat (5) @(negedge clk_sys);
    chk("pwm func hold", timer_out, p0);
    $display("test more done");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    bus = '0;
    rst = 1'b1;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_compare();
    t_clear_a();
    t_pwm();
    t_more();
    close_out();
  end
endmodule
